// ==== chfcr_map.svh ====
`ifndef CHFCR_MAP_SVH
`define CHFCR_MAP_SVH

// register offsets
`define CHFCR_ADDR_CMD 8'h00
`define CHFCR_ADDR_OWNER 8'h01
`define CHFCR_ADDR_FIFO 8'h02
`define CHFCR_ADDR_THR 8'h03

// command_control fields
`define CHFCR_CMD_STANDBY_BIT 7
`define CHFCR_CMD_RFOFF_BIT 6
`define CHFCR_CMD_CODE_HI 4
`define CHFCR_CMD_CODE_LO 0

// bus_owner_control fields
`define CHFCR_OWN_UNLOCK_BIT 7
`define CHFCR_OWN_HOST_BIT 6
`define CHFCR_OWN_SAM_BIT 5
`define CHFCR_OWN_PORT_HI 3
`define CHFCR_OWN_PORT_LO 2

// secure port select codes
`define CHFCR_PORT_OFF 2'h0
`define CHFCR_PORT_SPI 2'h1
`define CHFCR_PORT_I2CL 2'h2
`define CHFCR_PORT_I2C 2'h3

// fifo_setup fields
`define CHFCR_FIFO_DEPTH_BIT 7
`define CHFCR_FIFO_FULL_BIT 6
`define CHFCR_FIFO_EMPTY_BIT 5
`define CHFCR_FIFO_CLEAR_BIT 4
`define CHFCR_FIFO_THRMSB_BIT 2
`define CHFCR_FIFO_CNTMSB_HI 1
`define CHFCR_FIFO_CNTMSB_LO 0

// fifo depths, valid command mask and reset values
`define CHFCR_DEPTH_SMALL 10'h0ff
`define CHFCR_DEPTH_LARGE 10'h200
`define CHFCR_IDLE_CMD 5'h00
`define CHFCR_VALID_CMD_MASK 32'h0000ffff
`define CHFCR_RESET_BYTE 8'h00

`endif

// ==== chfcr_pkg.sv ====
package chfcr_pkg;

  typedef struct packed {
    logic [9:0] count;
  } chfcr_cnt_state_t;

  typedef struct packed {
    logic standby;
    logic rf_off;
    logic [4:0] cmd;
    logic cmd_start;
    logic idle_event;
    logic unlock;
    logic host_own;
    logic sam_own;
    logic [1:0] port_sel;
    logic [3:0] port_onehot;
    logic depth_sel;
    logic clear;
    logic thr_msb;
    logic [7:0] thr_low;
    logic near_full;
    logic near_empty;
    logic [7:0] rdata;
    logic rvalid;
  } chfcr_state_t;

endpackage

// ==== chfcr_fill_counter.sv ====
`timescale 1ns/1ns
`include "chfcr_map.svh"

module chfcr_fill_counter
  import chfcr_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic push,
  input wire logic pop,
  input wire logic clear,
  input wire logic depth_sel,
  // count
  output logic [CNT_W-1:0] count
);

  generate
    if (CNT_W != 10) begin : g_bad_width
      $error("chfcr_fill_counter: CNT_W must be 10");
    end
  endgenerate

  chfcr_cnt_state_t st;
  chfcr_cnt_state_t next_st;
  logic [9:0] depth;

  always_comb begin
    next_st = st;
    depth = depth_sel ? `CHFCR_DEPTH_SMALL : `CHFCR_DEPTH_LARGE;
    // clear beats any data port traffic in the same cycle
    if (clear) begin
      next_st.count = 10'h000;
    end else if (push && !pop && st.count < depth) begin
      next_st.count = st.count + 10'h001;
    end else if (pop && !push && st.count != 10'h000) begin
      next_st.count = st.count - 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

endmodule // chfcr_fill_counter

// ==== chfcr_regs.sv ====
`timescale 1ns/1ns
`include "chfcr_map.svh"

module chfcr_regs
  import chfcr_pkg::*;
#(
  parameter logic [31:0] VALID_CMD_MASK = `CHFCR_VALID_CMD_MASK,
  parameter logic [4:0] IDLE_CMD = `CHFCR_IDLE_CMD,
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // command engine
  input wire logic cmd_done,
  input wire logic wakeup,
  output logic [4:0] active_command,
  output logic command_start,
  output logic idle_event,
  output logic power_down_req,
  output logic rx_power_down,
  output logic tx_power_down,
  // bus ownership
  output logic host_owns_bus,
  output logic secure_module_owns_bus,
  output logic [1:0] secure_port_select,
  output logic secure_port_off,
  output logic secure_port_spi,
  output logic secure_port_i2cl,
  output logic secure_port_i2c,
  // fifo data port events and status
  input wire logic fifo_push,
  input wire logic fifo_pop,
  output logic fifo_clear,
  output logic fifo_depth_select,
  output logic [CNT_W-1:0] fill_count,
  output logic near_full_flag,
  output logic near_empty_flag
);

  generate
    if (CNT_W != 10) begin : g_bad_width
      $error("chfcr_regs: CNT_W must be 10");
    end
    if (VALID_CMD_MASK[IDLE_CMD] == 1'b0) begin : g_bad_idle
      $error("chfcr_regs: idle command must be a valid code");
    end
  endgenerate

  // reset release synchroniser
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  chfcr_state_t st;
  chfcr_state_t next_st;

  logic [9:0] count;
  logic [9:0] depth;
  logic [9:0] thr;
  logic [9:0] cnt_eff;
  logic wr_cmd;
  logic wr_own;
  logic wr_fifo;
  logic wr_thr;
  logic [4:0] new_cmd;
  logic want_host;
  logic want_sam;

  chfcr_fill_counter #(
    .CNT_W(CNT_W)
  ) u_fill (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(fifo_push),
    .pop(fifo_pop),
    .clear(st.clear),
    .depth_sel(st.depth_sel),
    .count(count)
  );

  always_comb begin
    next_st = st;
    wr_cmd = reg_wr && (reg_addr == `CHFCR_ADDR_CMD);
    wr_own = reg_wr && (reg_addr == `CHFCR_ADDR_OWNER);
    wr_fifo = reg_wr && (reg_addr == `CHFCR_ADDR_FIFO);
    wr_thr = reg_wr && (reg_addr == `CHFCR_ADDR_THR);
    new_cmd = reg_wdata[`CHFCR_CMD_CODE_HI:`CHFCR_CMD_CODE_LO];
    want_host = reg_wdata[`CHFCR_OWN_HOST_BIT];
    want_sam = reg_wdata[`CHFCR_OWN_SAM_BIT];

    // pulses last one cycle
    next_st.cmd_start = 1'b0;
    next_st.idle_event = 1'b0;
    next_st.clear = 1'b0;
    next_st.rvalid = 1'b0;

    // command engine finishing on its own returns to idle
    if (cmd_done && st.cmd != IDLE_CMD) begin
      next_st.cmd = IDLE_CMD;
      next_st.idle_event = 1'b1;
    end
    if (wakeup) begin
      next_st.standby = 1'b0;
    end

    // command_control write; bit 5 is dropped
    if (wr_cmd) begin
      next_st.standby = reg_wdata[`CHFCR_CMD_STANDBY_BIT];
      next_st.rf_off = reg_wdata[`CHFCR_CMD_RFOFF_BIT];
      if (VALID_CMD_MASK[new_cmd]) begin
        next_st.cmd = new_cmd;
        next_st.cmd_start = (new_cmd != IDLE_CMD);
      end else begin
        // an unknown code never reaches the engine
        next_st.cmd = IDLE_CMD;
        next_st.idle_event = 1'b1;
      end
    end

    // any write consumes the unlock
    if (reg_wr) begin
      next_st.unlock = 1'b0;
    end
    if (wr_own) begin
      next_st.port_sel = reg_wdata[`CHFCR_OWN_PORT_HI:`CHFCR_OWN_PORT_LO];
      if (st.unlock) begin
        // asking for both owners at once is refused as a whole
        if (!(want_host && want_sam)) begin
          next_st.host_own = want_host;
          next_st.sam_own = want_sam;
        end
      end else if (reg_wdata[`CHFCR_OWN_UNLOCK_BIT]) begin
        next_st.unlock = 1'b1;
      end
    end

    // one-hot decode of the secure port
    case (next_st.port_sel)
      `CHFCR_PORT_OFF: next_st.port_onehot = 4'h1;
      `CHFCR_PORT_SPI: next_st.port_onehot = 4'h2;
      `CHFCR_PORT_I2CL: next_st.port_onehot = 4'h4;
      `CHFCR_PORT_I2C: next_st.port_onehot = 4'h8;
      default: next_st.port_onehot = 4'h1;
    endcase

    // fifo_setup write; depth change is not guarded, software flushes first
    if (wr_fifo) begin
      next_st.depth_sel = reg_wdata[`CHFCR_FIFO_DEPTH_BIT];
      next_st.clear = reg_wdata[`CHFCR_FIFO_CLEAR_BIT];
      next_st.thr_msb = reg_wdata[`CHFCR_FIFO_THRMSB_BIT];
    end
    if (wr_thr) begin
      next_st.thr_low = reg_wdata;
    end

    // alert comparisons; cnt_eff never exceeds depth, so no wrap
    depth = st.depth_sel ? `CHFCR_DEPTH_SMALL : `CHFCR_DEPTH_LARGE;
    thr = {1'b0, st.depth_sel ? 1'b0 : st.thr_msb, st.thr_low};
    cnt_eff = st.depth_sel ? {2'b00, count[7:0]} : count;
    next_st.near_full = (depth - cnt_eff) <= thr;
    next_st.near_empty = cnt_eff <= thr;

    // read data; reserved and unmapped read zero
    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      case (reg_addr)
        `CHFCR_ADDR_CMD: begin
          next_st.rdata = {st.standby, st.rf_off, 1'b0, st.cmd};
        end
        `CHFCR_ADDR_OWNER: begin
          next_st.rdata = {st.unlock, st.host_own, st.sam_own, 1'b0,
                           st.port_sel, 2'b00};
        end
        `CHFCR_ADDR_FIFO: begin
          // flush bit always reads 0
          next_st.rdata = {st.depth_sel, st.near_full, st.near_empty, 1'b0, 1'b0,
                           st.thr_msb, count[9:8]};
        end
        `CHFCR_ADDR_THR: begin
          next_st.rdata = st.thr_low;
        end
        default: begin
          next_st.rdata = `CHFCR_RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cmd <= `CHFCR_IDLE_CMD;
      st.port_onehot <= 4'h1;
      st.near_empty <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign active_command = st.cmd;
  assign command_start = st.cmd_start;
  assign idle_event = st.idle_event;
  assign power_down_req = st.standby;
  assign rx_power_down = st.rf_off;
  assign tx_power_down = st.rf_off;
  assign host_owns_bus = st.host_own;
  assign secure_module_owns_bus = st.sam_own;
  assign secure_port_select = st.port_sel;
  assign secure_port_off = st.port_onehot[0];
  assign secure_port_spi = st.port_onehot[1];
  assign secure_port_i2cl = st.port_onehot[2];
  assign secure_port_i2c = st.port_onehot[3];
  assign fifo_clear = st.clear;
  assign fifo_depth_select = st.depth_sel;
  assign fill_count = count;
  assign near_full_flag = st.near_full;
  assign near_empty_flag = st.near_empty;

endmodule // chfcr_regs

// ==== chfcr_props.sv ====
`timescale 1ns/1ns
module chfcr_props #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // command and ownership
  input wire logic [4:0] active_command,
  input wire logic command_start,
  input wire logic idle_event,
  input wire logic power_down_req,
  input wire logic rx_power_down,
  input wire logic host_owns_bus,
  input wire logic secure_module_owns_bus,
  input wire logic secure_port_off,
  input wire logic secure_port_spi,
  input wire logic secure_port_i2cl,
  input wire logic secure_port_i2c,
  // fifo
  input wire logic fifo_push,
  input wire logic fifo_pop,
  input wire logic fifo_clear,
  input wire logic fifo_depth_select,
  input wire logic [CNT_W-1:0] fill_count
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic w0;
  logic [CNT_W-1:0] lim;
  assign w0 = reg_wr && reg_addr == 8'h00;
  // saturation follows the depth select
  assign lim = fifo_depth_select ? 10'h0ff : 10'h200;
  property p_stby; w0 && reg_wdata[7] |=> power_down_req; endproperty
  a_stby: assert property (p_stby) else $error("standby");
  property p_rf; w0 |=> rx_power_down == $past(reg_wdata[6]); endproperty
  a_rf: assert property (p_rf) else $error("rf off");
  property p_cmd;
    w0 && !reg_wdata[4] && reg_wdata[3:0] != 4'h0 |=>
      command_start && active_command == $past(reg_wdata[4:0]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command");
  property p_unk; w0 && reg_wdata[4] |=> active_command == 5'h00 && idle_event; endproperty
  a_unk: assert property (p_unk) else $error("unknown code");
  property p_excl; !(host_owns_bus && secure_module_owns_bus); endproperty
  a_excl: assert property (p_excl) else $error("two owners");
  property p_lock;
    $rose(host_owns_bus) || $rose(secure_module_owns_bus) |->
      $past(reg_wr) && $past(reg_addr) == 8'h01;
  endproperty
  a_lock: assert property (p_lock) else $error("owner change");
  property p_port;
    $onehot({secure_port_off, secure_port_spi, secure_port_i2cl, secure_port_i2c});
  endproperty
  a_port: assert property (p_port) else $error("port decode");
  property p_clr;
    reg_wr && reg_addr == 8'h02 && reg_wdata[4] |=> fifo_clear ##1 fill_count == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("flush");
  property p_cnt;
    fifo_push && !fifo_pop && !fifo_clear && fill_count < lim |=>
      fill_count == $past(fill_count) + 1'b1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count");
  property p_rsv; reg_rd && reg_addr == 8'h02 |=> reg_rdata[4:3] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("read zero");
  c_idle: cover property (idle_event);
  c_clr: cover property (fifo_clear);
  c_host: cover property (host_owns_bus);
endmodule // chfcr_props
bind chfcr_regs chfcr_props #(.CNT_W(CNT_W)) i_chfcr_props (.*);

// ==== chfcr_host.sv ====
`timescale 1ns/1ns
module chfcr_host (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // released lines show the inverse so stale values never look valid
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
  task automatic own(input logic [7:0] d);
    wr(8'h01, 8'h80 | (d & 8'h0c));
    wr(8'h01, d);
  endtask
  task automatic depth(input logic [7:0] d);
    wr(8'h02, 8'h10);
    wr(8'h02, d);
  endtask
endmodule // chfcr_host

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clk_sys, reset_n, reg_wr, reg_rd, reg_rvalid, cmd_done, wakeup, command_start;
  logic idle_event, power_down_req, rx_power_down, tx_power_down, host_owns_bus;
  logic secure_module_owns_bus, secure_port_off, secure_port_spi, secure_port_i2cl;
  logic secure_port_i2c, fifo_push, fifo_pop, fifo_clear, fifo_depth_select;
  logic near_full_flag, near_empty_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [4:0] active_command;
  logic [1:0] secure_port_select;
  logic [9:0] fill_count;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  chfcr_regs i_chfcr_regs (.*);
  chfcr_host i_chfcr_host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    i_chfcr_host.wr(a, v);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_chfcr_host.rd(a, d);
    chk(d, e);
  endtask
  // drive one event input; 0 push, 1 pop, 2 wakeup, 3 cmd_done
  task automatic drv(input int sel, input logic v);
    case (sel)
      0: fifo_push <= v;
      1: fifo_pop <= v;
      2: wakeup <= v;
      default: cmd_done <= v;
    endcase
  endtask
  // extra edge at the end lets the lagging flags settle
  task automatic train(input int sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      drv(sel, 1'b1);
    end
    @(posedge clk_sys);
    drv(sel, 1'b0);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_cmd();
    rchk(8'h00, 8'h00);
    rchk(8'h07, 8'h00);
    for (int c = 1; c < 16; c++) begin
      w(8'h00, 8'(c));
      chk({active_command, command_start}, {5'(c), 1'b1});
    end
    w(8'h00, 8'h13);
    chk({active_command, idle_event}, 6'h01);
    w(8'h00, 8'he3);
    chk({power_down_req, rx_power_down, tx_power_down}, 3'h7);
    rchk(8'h00, 8'hc3);
    train(2, 1);
    chk(power_down_req, 1'b0);
    train(3, 1);
    chk(active_command, 5'h00);
  endtask
  task automatic t_own();
    w(8'h01, 8'h40);
    chk(host_owns_bus, 1'b0);
    i_chfcr_host.own(8'h40);
    chk({host_owns_bus, secure_module_owns_bus}, 2'h2);
    i_chfcr_host.own(8'h60);
    chk({host_owns_bus, secure_module_owns_bus}, 2'h2);
    i_chfcr_host.own(8'h20);
    chk({host_owns_bus, secure_module_owns_bus}, 2'h1);
    w(8'h01, 8'h80);
    rchk(8'h01, 8'ha0);
    w(8'h03, 8'h00);
    rchk(8'h01, 8'h20);
    w(8'h01, 8'h40);
    chk(host_owns_bus, 1'b0);
    for (int p = 0; p < 4; p++) begin
      w(8'h01, 8'(p << 2) | 8'h13);
      chk({secure_port_select, secure_port_i2c, secure_port_i2cl, secure_port_spi,
           secure_port_off}, {2'(p), 4'(1 << p)});
    end
    rchk(8'h01, 8'h2c);
  endtask
  task automatic t_fifo();
    w(8'h03, 8'h05);
    rchk(8'h03, 8'h05);
    train(0, 5);
    chk({near_full_flag, near_empty_flag}, 2'h1);
    train(0, 1);
    chk({fill_count, near_empty_flag}, {10'h006, 1'b0});
    train(1, 2);
    chk(fill_count, 10'h004);
    w(8'h03, 8'hff);
    w(8'h02, 8'h04);
    train(0, 296);
    rchk(8'h02, 8'h65);
    i_chfcr_host.depth(8'h84);
    w(8'h03, 8'h05);
    chk(fill_count, 10'h000);
    rchk(8'h02, 8'ha4);
    train(0, 260);
    chk({fill_count, near_full_flag, near_empty_flag}, {10'h0ff, 2'h2});
    w(8'h02, 8'h94);
    chk({fifo_clear, fifo_depth_select}, 2'h3);
  endtask
  initial begin
    reset_n = 1'b0;
    {cmd_done, wakeup, fifo_push, fifo_pop} = 4'h0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_cmd();
    t_own();
    t_fifo();
    stop_test();
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
endmodule // tb
